//--- src/fcd_op_timer.sv
`timescale 1ns/100ps
`default_nettype none
module fcd_op_timer
    import fcd_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    fcd_timer_if.tmr    tif
);
    logic [TIMER_W-1:0] count_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_q <= TIMER_ZERO;
        end else if (tif.abort) begin
            count_q <= TIMER_ZERO;
        end else if (tif.start) begin
            count_q <= tif.length;
        end else if (tif.run && count_q != TIMER_ZERO) begin
            count_q <= count_q - TIMER_ONE;
        end
    end

    assign tif.done     = tif.run && !tif.start && count_q == TIMER_ONE;
    assign tif.at_point = (count_q & PAUSE_MASK) == TIMER_ZERO;
endmodule
`default_nettype wire

//--- src/fcd_pkg.sv
`default_nettype none
package fcd_pkg;

    localparam int unsigned ADDR_W   = 20;
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned BLOCK_HI = 19;
    localparam int unsigned BLOCK_LO = 16;
    localparam int unsigned BLOCK_W  = BLOCK_HI - BLOCK_LO + 1;
    localparam int unsigned TIMER_W  = 16;

    // command codes
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
    localparam logic [7:0] CMD_READ_ID      = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;
    localparam logic [7:0] CMD_PROG_ALT     = 8'h10;
    localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
    localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
    localparam logic [7:0] CMD_SUSPEND      = 8'hB0;

    // identifier values: arbitrary neutral values
    localparam logic [7:0] MAKER_CODE_DEF = 8'h5A;
    localparam logic [7:0] PART_CODE_DEF  = 8'h3C;

    // status byte field positions
    localparam int unsigned ST_READY   = 7;
    localparam int unsigned ST_SUSP    = 6;
    localparam int unsigned ST_EFAIL   = 5;
    localparam int unsigned ST_WFAIL   = 4;
    localparam int unsigned ST_SUPPLY  = 3;
    localparam logic [2:0]  ST_LOW_RSV = 3'h0;

    // internal operation lengths in clock cycles
    localparam logic [TIMER_W-1:0] PROG_CYCLES  = 16'h0010;
    localparam logic [TIMER_W-1:0] ERASE_CYCLES = 16'h0400;
    // erase may pause only where the low count bits are all zero
    localparam logic [TIMER_W-1:0] PAUSE_MASK   = 16'h000F;
    localparam logic [TIMER_W-1:0] TIMER_ZERO   = 16'h0000;
    localparam logic [TIMER_W-1:0] TIMER_ONE    = 16'h0001;

    typedef enum logic [1:0] {
        FCD_RD_ARRAY  = 2'b00,
        FCD_RD_STATUS = 2'b01,
        FCD_RD_ID     = 2'b11
    } fcd_read_mode_t;

    typedef enum logic [1:0] {
        FCD_CMD_IDLE   = 2'b00,
        FCD_CMD_PSETUP = 2'b01,
        FCD_CMD_ESETUP = 2'b11
    } fcd_cmd_state_t;

    typedef enum logic [1:0] {
        FCD_ENG_IDLE  = 2'b00,
        FCD_ENG_PROG  = 2'b01,
        FCD_ENG_ERASE = 2'b11,
        FCD_ENG_SUSP  = 2'b10
    } fcd_eng_state_t;

endpackage
`default_nettype wire

//--- src/fcd_status_latch.sv
`timescale 1ns/100ps
`default_nettype none
module fcd_status_latch
    import fcd_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              read_start_i,
    input  wire logic [DATA_W-1:0] status_i,
    output logic      [DATA_W-1:0] held_o
);
    // the byte shown to a read is frozen at the start of that read
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            held_o <= '0;
        end else if (read_start_i) begin
            held_o <= status_i;
        end
    end
endmodule
`default_nettype wire

//--- src/fcd_timer_if.sv
`timescale 1ns/100ps
`default_nettype none
interface fcd_timer_if;
    import fcd_pkg::*;
    logic                 start;
    logic [TIMER_W-1:0]   length;
    logic                 run;
    logic                 abort;
    logic                 done;
    logic                 at_point;

    modport ctrl (output start, output length, output run, output abort,
                  input done, input at_point);
    modport tmr  (input start, input length, input run, input abort,
                  output done, output at_point);
endinterface
`default_nettype wire

//--- src/fcd_top.sv
`timescale 1ns/100ps
`default_nettype none
module fcd_top
    import fcd_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = MAKER_CODE_DEF,
    parameter logic [7:0] PART_CODE  = PART_CODE_DEF
) (
    input  wire logic               clk_i,
    input  wire logic               resetn_i,
    input  wire logic               low_byte_select_n_i,
    input  wire logic               high_byte_select_n_i,
    input  wire logic               we_n_i,
    input  wire logic               oe_n_i,
    input  wire logic [ADDR_W-1:0]  addr_i,
    input  wire logic [DATA_W-1:0]  data_i,
    input  wire logic [DATA_W-1:0]  array_data_i,
    input  wire logic               programming_supply_high_i,
    input  wire logic               deep_sleep_i,
    input  wire logic               op_fail_i,
    output logic      [DATA_W-1:0]  data_o,
    output logic                    data_oe_o,
    output logic      [ADDR_W-1:0]  array_addr_o,
    output logic                    prog_start_o,
    output logic      [ADDR_W-1:0]  prog_addr_o,
    output logic      [DATA_W-1:0]  prog_data_o,
    output logic                    erase_start_o,
    output logic                    erase_busy_o,
    output logic      [BLOCK_W-1:0] erase_block_o,
    output logic                    card_ready_line_o
);

    ////////////////////////////////////////////////////////////////////////
    // reset release and strobe sampling

    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    logic selected;
    logic we_n_q;
    logic read_act_q;
    logic read_act;
    logic write_evt;
    logic read_start;
    logic sleep_q;

    assign selected   = !low_byte_select_n_i || !high_byte_select_n_i;
    assign read_act   = selected && !oe_n_i;
    // commands and data are taken when the write strobe rises
    assign write_evt  = we_n_i && !we_n_q && selected;
    // a read begins at whichever of strobe or select falls last
    assign read_start = read_act && !read_act_q;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            we_n_q     <= 1'b1;
            read_act_q <= 1'b0;
            sleep_q    <= 1'b0;
        end else begin
            we_n_q     <= we_n_i;
            read_act_q <= read_act;
            sleep_q    <= deep_sleep_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state

    fcd_read_mode_t mode_q;
    fcd_cmd_state_t cmd_q;
    fcd_eng_state_t eng_q;
    logic           susp_req_q;
    logic           efail_q;
    logic           wfail_q;
    logic           supply_q;
    logic [7:0]     cmd;
    logic           in_frozen_block;
    logic           supply_ok;
    logic           running;
    logic           sleep_exit;

    fcd_timer_if tif ();

    assign cmd        = data_i;
    assign supply_ok  = programming_supply_high_i;
    assign running    = eng_q == FCD_ENG_PROG || eng_q == FCD_ENG_ERASE;
    assign sleep_exit = sleep_q && !deep_sleep_i;
    assign in_frozen_block = addr_i[BLOCK_HI:BLOCK_LO] == erase_block_o;

    // events decoded from the host write
    logic do_prog;
    logic do_erase;
    logic bad_confirm;
    logic low_supply_op;
    logic do_clear;
    logic do_suspend;
    logic do_resume;
    logic pause_now;
    logic supply_abort;

    always_comb begin
        do_prog       = 1'b0;
        do_erase      = 1'b0;
        bad_confirm   = 1'b0;
        low_supply_op = 1'b0;
        do_clear      = 1'b0;
        do_suspend    = 1'b0;
        do_resume     = 1'b0;
        if (write_evt && !deep_sleep_i) begin
            case (eng_q)
                FCD_ENG_IDLE: begin
                    case (cmd_q)
                        FCD_CMD_PSETUP: begin
                            do_prog       = supply_ok;
                            low_supply_op = !supply_ok;
                        end
                        FCD_CMD_ESETUP: begin
                            if (cmd == CMD_CONFIRM) begin
                                do_erase      = supply_ok;
                                low_supply_op = !supply_ok;
                            end else begin
                                bad_confirm = 1'b1;
                            end
                        end
                        default: begin
                            do_clear = cmd == CMD_CLEAR_STATUS;
                        end
                    endcase
                end
                FCD_ENG_ERASE: begin
                    do_suspend = cmd == CMD_SUSPEND;
                end
                FCD_ENG_SUSP: begin
                    do_resume = cmd == CMD_CONFIRM;
                end
                default: begin
                end
            endcase
        end
    end

    assign pause_now    = eng_q == FCD_ENG_ERASE && susp_req_q
                          && tif.at_point;
    assign supply_abort = eng_q != FCD_ENG_IDLE && !supply_ok;

    ////////////////////////////////////////////////////////////////////////
    // command front end: read mode and setup sequencing

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= FCD_RD_ARRAY;
            cmd_q  <= FCD_CMD_IDLE;
        end else if (deep_sleep_i || sleep_exit) begin
            mode_q <= FCD_RD_ARRAY;
            cmd_q  <= FCD_CMD_IDLE;
        end else if (write_evt) begin
            cmd_q <= FCD_CMD_IDLE;
            case (eng_q)
                FCD_ENG_IDLE: begin
                    if (cmd_q != FCD_CMD_IDLE) begin
                        mode_q <= FCD_RD_STATUS;
                    end else begin
                        case (cmd)
                            CMD_READ_ARRAY: mode_q <= FCD_RD_ARRAY;
                            CMD_READ_ID: mode_q <= FCD_RD_ID;
                            CMD_READ_STATUS: mode_q <= FCD_RD_STATUS;
                            CMD_CLEAR_STATUS: mode_q <= FCD_RD_ARRAY;
                            CMD_PROG_SETUP, CMD_PROG_ALT: begin
                                cmd_q <= FCD_CMD_PSETUP;
                            end
                            CMD_ERASE_SETUP: cmd_q <= FCD_CMD_ESETUP;
                            default: mode_q <= FCD_RD_ARRAY;
                        endcase
                    end
                end
                FCD_ENG_SUSP: begin
                    case (cmd)
                        CMD_READ_ARRAY: mode_q <= FCD_RD_ARRAY;
                        CMD_READ_STATUS: mode_q <= FCD_RD_STATUS;
                        CMD_CONFIRM: mode_q <= FCD_RD_STATUS;
                        default: begin
                        end
                    endcase
                end
                default: begin
                    // program or erase running: array-read is not seen
                    if (cmd == CMD_READ_STATUS) begin
                        mode_q <= FCD_RD_STATUS;
                    end
                end
            endcase
        end else if (running) begin
            mode_q <= FCD_RD_STATUS;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write state machine

    assign tif.start  = do_prog || do_erase;
    assign tif.length = do_erase ? ERASE_CYCLES : PROG_CYCLES;
    assign tif.run    = running;
    assign tif.abort  = supply_abort;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            eng_q      <= FCD_ENG_IDLE;
            susp_req_q <= 1'b0;
        end else begin
            case (eng_q)
                FCD_ENG_IDLE: begin
                    susp_req_q <= 1'b0;
                    if (do_prog) begin
                        eng_q <= FCD_ENG_PROG;
                    end else if (do_erase) begin
                        eng_q <= FCD_ENG_ERASE;
                    end
                end
                FCD_ENG_PROG: begin
                    if (supply_abort || tif.done) begin
                        eng_q <= FCD_ENG_IDLE;
                    end
                end
                FCD_ENG_ERASE: begin
                    if (do_suspend) begin
                        susp_req_q <= 1'b1;
                    end
                    if (supply_abort || tif.done) begin
                        eng_q <= FCD_ENG_IDLE;
                    end else if (pause_now) begin
                        eng_q      <= FCD_ENG_SUSP;
                        susp_req_q <= 1'b0;
                    end
                end
                FCD_ENG_SUSP: begin
                    if (supply_abort) begin
                        eng_q <= FCD_ENG_IDLE;
                    end else if (do_resume) begin
                        eng_q <= FCD_ENG_ERASE;
                    end
                end
                default: eng_q <= FCD_ENG_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky status bits; a set wins over a clear in the same cycle

    logic set_efail;
    logic set_wfail;

    assign set_efail = bad_confirm
        || (cmd_q == FCD_CMD_ESETUP && low_supply_op)
        || (eng_q == FCD_ENG_ERASE && tif.done && op_fail_i)
        || (supply_abort && eng_q != FCD_ENG_PROG);
    assign set_wfail = bad_confirm
        || (cmd_q == FCD_CMD_PSETUP && low_supply_op)
        || (eng_q == FCD_ENG_PROG && tif.done && op_fail_i)
        || (supply_abort && eng_q == FCD_ENG_PROG);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            efail_q <= 1'b0;
        end else if (set_efail) begin
            efail_q <= 1'b1;
        end else if (do_clear) begin
            efail_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wfail_q <= 1'b0;
        end else if (set_wfail) begin
            wfail_q <= 1'b1;
        end else if (do_clear) begin
            wfail_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            supply_q <= 1'b0;
        end else if (low_supply_op || supply_abort) begin
            supply_q <= 1'b1;
        end else if (do_clear) begin
            supply_q <= 1'b0;
        end
    end

    logic [DATA_W-1:0] status_live;
    logic [DATA_W-1:0] status_held;

    assign status_live = {!running, eng_q == FCD_ENG_SUSP, efail_q,
                          wfail_q, supply_q, ST_LOW_RSV};

    fcd_status_latch u_status (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n),
        .read_start_i (read_start),
        .status_i     (status_live),
        .held_o       (status_held)
    );

    fcd_op_timer u_timer (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .tif     (tif)
    );

    ////////////////////////////////////////////////////////////////////////
    // operation outputs

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            prog_start_o  <= 1'b0;
            prog_addr_o   <= '0;
            prog_data_o   <= '0;
            erase_start_o <= 1'b0;
            erase_block_o <= '0;
        end else begin
            prog_start_o  <= do_prog;
            erase_start_o <= do_erase;
            if (do_prog) begin
                prog_addr_o <= addr_i;
                prog_data_o <= data_i;
            end
            if (do_erase) begin
                erase_block_o <= addr_i[BLOCK_HI:BLOCK_LO];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            erase_busy_o      <= 1'b0;
            card_ready_line_o <= 1'b1;
        end else begin
            erase_busy_o      <= eng_q == FCD_ENG_ERASE;
            card_ready_line_o <= !running;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data path

    logic [DATA_W-1:0] read_d;
    logic              show_status;

    // a read of the block under erase during suspend shows status
    assign show_status = mode_q == FCD_RD_STATUS || running
        || (eng_q == FCD_ENG_SUSP && in_frozen_block);

    always_comb begin
        if (show_status) begin
            read_d = status_held;
        end else if (mode_q == FCD_RD_ID) begin
            read_d = addr_i[0] ? PART_CODE : MAKER_CODE;
        end else begin
            read_d = array_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            data_o       <= '0;
            data_oe_o    <= 1'b0;
            array_addr_o <= '0;
        end else begin
            data_o       <= read_d;
            data_oe_o    <= read_act;
            array_addr_o <= addr_i;
        end
    end

endmodule
`default_nettype wire

//--- verif/fcd_array_model.sv
`timescale 1ns/100ps
`default_nettype none
module fcd_array_model
    import fcd_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic [ADDR_W-1:0] array_addr_i,
    input  wire logic              prog_start_i,
    input  wire logic [ADDR_W-1:0] prog_addr_i,
    input  wire logic [DATA_W-1:0] prog_data_i,
    input  wire logic              fail_req_i,
    output logic      [DATA_W-1:0] array_data_o,
    output logic                   op_fail_o
);
logic [DATA_W-1:0] mem [16];
initial for (int i = 0; i < 16; i++) mem[i] = {4'hC, 4'(i)};
// behavioural cell array: a started program lands in the cell
always @(posedge clk_i) if (prog_start_i) mem[prog_addr_i[3:0]] <= prog_data_i;
assign array_data_o = mem[array_addr_i[3:0]];
assign op_fail_o    = fail_req_i;
endmodule
`default_nettype wire

//--- verif/fcd_checker.sv
`timescale 1ns/100ps
`default_nettype none
module fcd_checker
    import fcd_pkg::*;
(
    input wire logic               clk_i,
    input wire logic               resetn_i,
    input wire logic               oe_n_i,
    input wire logic [ADDR_W-1:0]  addr_i,
    input wire logic [ADDR_W-1:0]  array_addr_o,
    input wire logic               data_oe_o,
    input wire logic               prog_start_o,
    input wire logic               erase_start_o,
    input wire logic               erase_busy_o,
    input wire logic [BLOCK_W-1:0] erase_block_o,
    input wire logic               card_ready_line_o
);
default clocking cb @(posedge clk_i); endclocking
default disable iff (!resetn_i);
////////////////////////////////////////////////////////////////////////
property p_prog_pulse; prog_start_o |=> !prog_start_o; endproperty
a_prog_pulse: assert property (p_prog_pulse)
    else $error("program start pulse too long");
property p_erase_pulse; erase_start_o |=> !erase_start_o; endproperty
a_erase_pulse: assert property (p_erase_pulse)
    else $error("erase start pulse too long");
property p_prog_busy; prog_start_o |=> !card_ready_line_o [*8]; endproperty
a_prog_busy: assert property (p_prog_busy)
    else $error("ready line high during program");
property p_prog_done; prog_start_o |-> ##[1:40] card_ready_line_o; endproperty
a_prog_done: assert property (p_prog_done)
    else $error("program never completed");
property p_erase_busy;
    erase_start_o |-> ##[0:1] !card_ready_line_o;
endproperty
a_erase_busy: assert property (p_erase_busy)
    else $error("ready line high at erase start");
property p_block_frozen;
    erase_busy_o && $past(erase_busy_o, 2) |-> $stable(erase_block_o);
endproperty
a_block_frozen: assert property (p_block_frozen)
    else $error("erase block changed during erase");
property p_fall_cause;
    $fell(card_ready_line_o) |-> $past(prog_start_o) || erase_start_o
        || erase_busy_o;
endproperty
a_fall_cause: assert property (p_fall_cause)
    else $error("ready line fell without an operation");
property p_addr_pass; ##1 array_addr_o == $past(addr_i); endproperty
a_addr_pass: assert property (p_addr_pass)
    else $error("array address not passed through");
property p_oe_off; oe_n_i |=> !data_oe_o; endproperty
a_oe_off: assert property (p_oe_off)
    else $error("data driven without read strobe");
c_prog: cover property (prog_start_o);
c_erase: cover property (erase_start_o);
c_susp: cover property ($rose(card_ready_line_o) && $past(erase_busy_o));
endmodule
bind fcd_top fcd_checker u_fcd_checker (.clk_i(clk_i),
    .resetn_i(resetn_i), .oe_n_i(oe_n_i), .addr_i(addr_i),
    .array_addr_o(array_addr_o), .data_oe_o(data_oe_o),
    .prog_start_o(prog_start_o), .erase_start_o(erase_start_o),
    .erase_busy_o(erase_busy_o), .erase_block_o(erase_block_o),
    .card_ready_line_o(card_ready_line_o));
`default_nettype wire

//--- verif/fcd_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module fcd_top_tb;
import fcd_pkg::*;
logic              clk = 0, resetn = 0, sel_n = 1, hsel_n = 1;
logic              we_n = 1, oe_n = 1, vpp = 1, sleep = 0, freq = 0;
logic [ADDR_W-1:0] addr = '0, aaddr, paddr;
logic [DATA_W-1:0] din = '0, dout, arr, pdata;
logic              doe, pst, est, ebusy, rdy, ofail;
logic [BLOCK_W-1:0] blk;
int                num_errors = 0, n_checks = 0;
always #20 clk = ~clk;
fcd_top u_fcd_top (.clk_i(clk), .resetn_i(resetn),
    .low_byte_select_n_i(sel_n), .high_byte_select_n_i(hsel_n),
    .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(addr), .data_i(din),
    .array_data_i(arr), .programming_supply_high_i(vpp),
    .deep_sleep_i(sleep), .op_fail_i(ofail), .data_o(dout),
    .data_oe_o(doe), .array_addr_o(aaddr), .prog_start_o(pst),
    .prog_addr_o(paddr), .prog_data_o(pdata), .erase_start_o(est),
    .erase_busy_o(ebusy), .erase_block_o(blk), .card_ready_line_o(rdy));
fcd_array_model u_fcd_array_model (.clk_i(clk), .array_addr_i(aaddr),
    .prog_start_i(pst), .prog_addr_i(paddr), .prog_data_i(pdata),
    .fail_req_i(freq), .array_data_o(arr), .op_fail_o(ofail));
////////////////////////////////////////////////////////////////////////
task automatic chk(input string n, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
        num_errors++;
        $display("unexpected %s: expected %h seen %h", n, e, g);
    end
endtask
task automatic wr(input logic [7:0] c, input logic [ADDR_W-1:0] a);
    @(negedge clk);
    sel_n = 0; we_n = 0; addr = a; din = c;
    @(negedge clk);
    we_n = 1;
    @(negedge clk);
    sel_n = 1;
    @(negedge clk);
endtask
// select and strobe rise after every read so status refreshes
task automatic rd_chk(input string n, input logic [ADDR_W-1:0] a,
                      input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(negedge clk);
    sel_n = 0; oe_n = 0; addr = a;
    repeat (3) @(negedge clk);
    chk(n, e, dout & m);
    oe_n = 1; sel_n = 1;
endtask
task automatic wait_rdy(input logic v);
    int k;
    k = 0;
    while (rdy !== v && k < 3000) begin
        @(negedge clk);
        k++;
    end
    chk("ready line", {7'h00, v}, {7'h00, rdy});
endtask
task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////
initial begin
    #(40 * 20000);
    num_errors++;
    complete_run;
end
initial begin
    repeat (10) @(negedge clk);
    resetn = 1;
    repeat (4) @(negedge clk);
    rd_chk("array after reset", 20'h00003, 8'hC3);
    wr(CMD_READ_ID, 20'h00000);
    rd_chk("maker code", 20'hFFFF0, MAKER_CODE_DEF);
    rd_chk("part code", 20'h5A5A1, PART_CODE_DEF);
    wr(CMD_READ_STATUS, 20'h00000);
    rd_chk("idle status", 20'h12345, 8'h80);
    wr(8'h33, 20'h00000);
    rd_chk("reserved code", 20'h00004, 8'hC4);
    wr(CMD_PROG_SETUP, 20'h00005);
    wr(8'hA5, 20'h00005);
    wr(CMD_READ_ARRAY, 20'h00005);
    rd_chk("busy status", 20'h00005, 8'h00);
    wait_rdy(1'b1);
    rd_chk("done status", 20'h00005, 8'h80);
    wr(CMD_READ_ARRAY, 20'h00000);
    rd_chk("programmed byte", 20'h00005, 8'hA5);
    freq = 1;
    wr(CMD_PROG_ALT, 20'h00006);
    wr(8'h5C, 20'h00006);
    wait_rdy(1'b1);
    freq = 0;
    rd_chk("write failure", 20'h00000, 8'h90);
    wr(CMD_CLEAR_STATUS, 20'h00000);
    rd_chk("array after clear", 20'h00006, 8'h5C);
    wr(CMD_ERASE_SETUP, 20'h30000);
    wr(8'h77, 20'h30000);
    rd_chk("bad confirm", 20'h00000, 8'hB0);
    wr(CMD_CLEAR_STATUS, 20'h00000);
    wr(CMD_ERASE_SETUP, 20'h30000);
    wr(CMD_CONFIRM, 20'h3FFFF);
    chk("erase block", 8'h03, {4'h0, blk});
    wr(CMD_CLEAR_STATUS, 20'h00000);
    wr(CMD_READ_ARRAY, 20'h00000);
    rd_chk("erase status", 20'h00000, 8'h00);
    wr(CMD_SUSPEND, 20'h00000);
    wait_rdy(1'b1);
    rd_chk("suspended", 20'h00000, 8'hC0);
    wr(CMD_READ_ARRAY, 20'h00000);
    rd_chk("read in suspend", 20'h00003, 8'hC3);
    wr(CMD_CONFIRM, 20'h00000);
    wait_rdy(1'b0);
    rd_chk("resumed", 20'h00000, 8'h00);
    wait_rdy(1'b1);
    rd_chk("erase done", 20'h00000, 8'h80);
    vpp = 0;
    wr(CMD_ERASE_SETUP, 20'h20000);
    wr(CMD_CONFIRM, 20'h20000);
    rd_chk("low supply erase", 20'h00000, 8'hA8);
    wr(CMD_CLEAR_STATUS, 20'h00000);
    wr(CMD_READ_STATUS, 20'h00000);
    rd_chk("clear at low supply", 20'h00000, 8'h80);
    vpp = 1;
    wr(CMD_ERASE_SETUP, 20'h10000);
    wr(CMD_CONFIRM, 20'h10000);
    wr(CMD_SUSPEND, 20'h00000);
    wait_rdy(1'b1);
    vpp = 0;
    rd_chk("abort in suspend", 20'h00000, 8'h88, 8'h88);
    vpp = 1;
    wr(CMD_CLEAR_STATUS, 20'h00000);
    wr(CMD_READ_STATUS, 20'h00000);
    sleep = 1;
    repeat (2) @(negedge clk);
    sleep = 0;
    rd_chk("sleep exit", 20'h00004, 8'hC4);
    @(negedge clk);
    hsel_n = 0; oe_n = 0; addr = 20'h00003;
    repeat (3) @(negedge clk);
    chk("high select read", 8'hC3, dout);
    chk("data enable", 8'h01, {7'h00, doe});
    oe_n = 1; hsel_n = 1;
    complete_run;
end
endmodule
`default_nettype wire
